// File: include/mgmt_irq_pkg.sv
// Purpose: Constants and carrier types of the management interrupt group
// Assumes: Register word index times four gives the AXI4-Lite byte address
// Notes: Rules of operation follow
package mgmt_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_LSB = 2;

  // Printed offsets are word indices
  localparam logic [5:0] IDX_PORT1_STS = 6'h15;
  localparam logic [5:0] IDX_PERIPH_EN = 6'h16;
  localparam logic [5:0] IDX_MISC_EN = 6'h17;
  localparam logic [5:0] IDX_PORT2_EN = 6'h18;
  localparam logic [5:0] IDX_PORT34_EN = 6'h19;
  localparam logic [5:0] IDX_PORT5_EN = 6'h1a;

  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [REG_W-1:0] PERIPH_EN_MASK = 8'h9e;
  localparam logic [REG_W-1:0] MISC_SRC_MASK = 8'h1f;

  localparam int MISC_RING_B_BIT = 5;
  localparam int MISC_ROUTE_SERIAL_BIT = 6;
  localparam int MISC_ROUTE_PIN_BIT = 7;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pending source levels, bit-aligned with their enable registers
  typedef struct packed {
    logic [REG_W-1:0] port5;
    logic [REG_W-1:0] port34;
    logic [REG_W-1:0] port2;
    logic [REG_W-1:0] misc;
    logic [REG_W-1:0] periph;
  } irq_sources_t;

  typedef struct packed {
    logic [REG_W-1:0] port5;
    logic [REG_W-1:0] port34;
    logic [REG_W-1:0] port2;
    logic [REG_W-1:0] misc;
    logic [REG_W-1:0] periph;
  } irq_enables_t;

endpackage

// File: hdl/event_flag.sv
// Purpose: One sticky event flag with write-one clear
// Assumes: set and clr come from logic on aclk
// Notes: Set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module event_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clr,
  output logic flag_r
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 1'b0;
    end else if (set) begin
      flag_r <= 1'b1;
    end else if (clr) begin
      flag_r <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: hdl/mgmt_irq_group.sv
// Purpose: Port-1 event status, five enable registers, combined interrupt
// Assumes: Pending sources arrive on aclk; port-1 pins are asynchronous
// Notes: AXI4-Lite slave, one read in flight at most; a second write is held until the first write response is taken
`timescale 1ns/1ps
`default_nettype none
module mgmt_irq_group
  import mgmt_irq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [REG_W-1:0] port1_pins,
  input wire logic [REG_W-1:0] port1_event_gate,
  input wire irq_sources_t sources,
  output logic combined_mgmt_irq_n,
  output logic mgmt_irq_out_pin_n,
  output logic mgmt_irq_serial
);

  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [DATA_W-1:0] rdata_r;
  logic aw_hold_r, w_hold_r;
  logic aw_hold_nxt, w_hold_nxt;
  logic [ADDR_W-1:0] awaddr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_take, w_take, ar_take, wr_fire;
  logic [5:0] wr_idx, rd_idx;
  logic wr_byte0;
  logic [REG_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
  logic [REG_W-1:0] pin_rise;
  logic [REG_W-1:0] status_r;
  logic [REG_W-1:0] status_clr;
  irq_enables_t en_r;
  logic [REG_W-1:0] misc_gate;
  logic irq_any;
  logic combined_n_r, pin_n_r, serial_r;

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign combined_mgmt_irq_n = combined_n_r;
  assign mgmt_irq_out_pin_n = pin_n_r;
  assign mgmt_irq_serial = serial_r;

  // Write channel handshakes; address and data taken in either order
  assign aw_take = awvalid & awready_r;
  assign w_take = wvalid & wready_r;
  assign wr_fire = aw_hold_r & w_hold_r & ~bvalid_r;
  assign aw_hold_nxt = (aw_hold_r | aw_take) & ~wr_fire;
  assign w_hold_nxt = (w_hold_r | w_take) & ~wr_fire;
  assign wr_idx = awaddr_r[ADDR_W-1:IDX_LSB];
  assign wr_byte0 = wr_fire & wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awready_r <= ~aw_hold_nxt;
      wready_r <= ~w_hold_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else begin
      if (aw_take) begin
        awaddr_r <= awaddr;
      end
      if (w_take) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      unique case (wr_idx)
        IDX_PORT1_STS, IDX_PERIPH_EN, IDX_MISC_EN,
        IDX_PORT2_EN, IDX_PORT34_EN, IDX_PORT5_EN: bresp_r <= RESP_OKAY;
        default: bresp_r <= RESP_SLVERR;
      endcase
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Enable registers; reserved peripheral bits never store
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= '{REG_RESET, REG_RESET, REG_RESET, REG_RESET, REG_RESET};
    end else if (wr_byte0) begin
      unique case (wr_idx)
        IDX_PERIPH_EN: en_r.periph <= wdata_r[REG_W-1:0] & PERIPH_EN_MASK;
        IDX_MISC_EN: en_r.misc <= wdata_r[REG_W-1:0];
        IDX_PORT2_EN: en_r.port2 <= wdata_r[REG_W-1:0];
        IDX_PORT34_EN: en_r.port34 <= wdata_r[REG_W-1:0];
        IDX_PORT5_EN: en_r.port5 <= wdata_r[REG_W-1:0];
        default: ;
      endcase
    end
  end

  // Read channel: one read in flight, data registered at acceptance
  assign ar_take = arvalid & arready_r;
  assign rd_idx = araddr[ADDR_W-1:IDX_LSB];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
    end else begin
      arready_r <= ~(ar_take | (rvalid_r & ~rready));
      if (ar_take) begin
        rvalid_r <= 1'b1;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
      unique case (rd_idx)
        IDX_PORT1_STS: rdata_r[REG_W-1:0] <= status_r;
        IDX_PERIPH_EN: rdata_r[REG_W-1:0] <= en_r.periph;
        IDX_MISC_EN: rdata_r[REG_W-1:0] <= en_r.misc;
        IDX_PORT2_EN: rdata_r[REG_W-1:0] <= en_r.port2;
        IDX_PORT34_EN: rdata_r[REG_W-1:0] <= en_r.port34;
        IDX_PORT5_EN: rdata_r[REG_W-1:0] <= en_r.port5;
        default: rresp_r <= RESP_SLVERR;
      endcase
    end
  end

  // Pins are asynchronous: two stages, then a third for the edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
    end else begin
      pin_s1_r <= port1_pins;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r & ~pin_s3_r;
  assign status_clr = (wr_byte0 && wr_idx == IDX_PORT1_STS) ? wdata_r[REG_W-1:0] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < REG_W; gi++) begin : g_flag
      event_flag u_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(pin_rise[gi]),
        .clr(status_clr[gi]),
        .flag_r(status_r[gi])
      );
    end
  endgenerate

  // Ring indicator b gate reads inverted; route bits never gate a source
  always_comb begin
    misc_gate = en_r.misc & MISC_SRC_MASK;
    misc_gate[MISC_RING_B_BIT] = ~en_r.misc[MISC_RING_B_BIT];
  end

  assign irq_any = |(sources.periph & en_r.periph)
                 | |(sources.misc & misc_gate)
                 | |(sources.port2 & en_r.port2)
                 | |(sources.port34 & en_r.port34)
                 | |(sources.port5 & en_r.port5)
                 | |(status_r & port1_event_gate);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      combined_n_r <= 1'b1;
      pin_n_r <= 1'b1;
      serial_r <= 1'b0;
    end else begin
      combined_n_r <= ~irq_any;
      pin_n_r <= ~(irq_any & en_r.misc[MISC_ROUTE_PIN_BIT]);
      serial_r <= irq_any & en_r.misc[MISC_ROUTE_SERIAL_BIT];
    end
  end

  // Checks
  sequence s_sts_clear_write;
    wr_byte0 && wr_idx == IDX_PORT1_STS && pin_rise == '0;
  endsequence

  property p_w1c_clears;
    @(posedge aclk) disable iff (!aresetn)
    s_sts_clear_write |=> (status_r & $past(wdata_r[REG_W-1:0])) == '0;
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("status bit not cleared");

  property p_pin_sets_flag;
    @(posedge aclk) disable iff (!aresetn)
    pin_s2_r[0] && !pin_s3_r[0] |=> status_r[0] ##1 status_r[0] || $past(status_clr[0]);
  endproperty
  a_pin_sets_flag: assert property (p_pin_sets_flag) else $error("pin 0 event lost");

  property p_disabled_quiet;
    @(posedge aclk) disable iff (!aresetn)
    (en_r == '0 && en_r.misc[MISC_RING_B_BIT] == 1'b0 && !sources.misc[MISC_RING_B_BIT]
      && (status_r & port1_event_gate) == '0) |=> combined_n_r;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("blocked source fired");

  property p_periph_mask;
    @(posedge aclk) disable iff (!aresetn)
    wr_byte0 && wr_idx == IDX_PERIPH_EN |=> en_r.periph == ($past(wdata_r[REG_W-1:0]) & PERIPH_EN_MASK);
  endproperty
  a_periph_mask: assert property (p_periph_mask) else $error("peripheral enable wrong");

  property p_misc_source;
    @(posedge aclk) disable iff (!aresetn)
    (sources.misc & en_r.misc & MISC_SRC_MASK) != '0 |=> !combined_n_r;
  endproperty
  a_misc_source: assert property (p_misc_source) else $error("misc source not passed");

  property p_route;
    @(posedge aclk) disable iff (!aresetn)
    !combined_n_r |-> (pin_n_r == !$past(en_r.misc[MISC_ROUTE_PIN_BIT]))
      && (serial_r == $past(en_r.misc[MISC_ROUTE_SERIAL_BIT]));
  endproperty
  a_route: assert property (p_route) else $error("routing mismatch");

  property p_port_sources;
    @(posedge aclk) disable iff (!aresetn)
    ((sources.port2 & en_r.port2) | (sources.port34 & en_r.port34)
      | (sources.port5 & en_r.port5)) != '0 |=> !combined_n_r;
  endproperty
  a_port_sources: assert property (p_port_sources) else $error("port source not passed");

  property p_release;
    @(posedge aclk) disable iff (!aresetn)
    !irq_any [*2] |-> ##1 combined_n_r && pin_n_r && !serial_r;
  endproperty
  a_release: assert property (p_release) else $error("interrupt not released");

  property p_ring_b_low;
    @(posedge aclk) disable iff (!aresetn)
    sources.misc[MISC_RING_B_BIT] && !en_r.misc[MISC_RING_B_BIT] |=> !combined_n_r;
  endproperty
  a_ring_b_low: assert property (p_ring_b_low) else $error("ring b not passed on zero");

  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    ar_take |=> rvalid_r && !arready_r;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered");

  sequence s_status_read;
    ar_take && rd_idx == IDX_PORT1_STS;
  endsequence

  property p_status_read;
    @(posedge aclk) disable iff (!aresetn)
    s_status_read |=> rvalid_r && rdata_r[REG_W-1:0] == $past(status_r)
      && rdata_r[DATA_W-1:REG_W] == '0;
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_port5_read;
    @(posedge aclk) disable iff (!aresetn)
    ar_take && rd_idx == IDX_PORT5_EN |=> rdata_r[REG_W-1:0] == $past(en_r.port5);
  endproperty
  a_port5_read: assert property (p_port5_read) else $error("port5 enable read wrong");

  property p_port2_store;
    @(posedge aclk) disable iff (!aresetn)
    wr_byte0 && wr_idx == IDX_PORT2_EN |=> en_r.port2 == $past(wdata_r[REG_W-1:0]);
  endproperty
  a_port2_store: assert property (p_port2_store) else $error("port2 enable not stored");

  property p_misc_store;
    @(posedge aclk) disable iff (!aresetn)
    wr_byte0 && wr_idx == IDX_MISC_EN |=> en_r.misc == $past(wdata_r[REG_W-1:0]);
  endproperty
  a_misc_store: assert property (p_misc_store) else $error("misc enable not stored");

  property p_strobe_guard;
    @(posedge aclk) disable iff (!aresetn)
    wr_fire && !wstrb_r[0] |=> $stable(en_r);
  endproperty
  a_strobe_guard: assert property (p_strobe_guard) else $error("unstrobed write stored");

  property p_port1_gate;
    @(posedge aclk) disable iff (!aresetn)
    (status_r & port1_event_gate) != '0 |=> !combined_n_r;
  endproperty
  a_port1_gate: assert property (p_port1_gate) else $error("port1 event not passed");

  property p_periph_source;
    @(posedge aclk) disable iff (!aresetn)
    (sources.periph & en_r.periph) != '0 |=> !combined_n_r;
  endproperty
  a_periph_source: assert property (p_periph_source) else $error("periph source lost");

  property p_route_off;
    @(posedge aclk) disable iff (!aresetn)
    !en_r.misc[MISC_ROUTE_PIN_BIT] && !en_r.misc[MISC_ROUTE_SERIAL_BIT] |=> pin_n_r && !serial_r;
  endproperty
  a_route_off: assert property (p_route_off) else $error("unrouted request seen");

endmodule
`default_nettype wire

// File: sim/mgmt_irq_host.sv
// Purpose: Host side that receives the management interrupt
// Assumes: Pin request active low, serial request active high
// Notes: Counts delivered requests only; it never answers back
`timescale 1ns/1ps
`default_nettype none
module mgmt_irq_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_n,
  input wire logic serial,
  output int hits
);
  logic pin_q;
  logic ser_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b1;
      ser_q <= 1'b0;
      hits <= 0;
    end else begin
      pin_q <= pin_n;
      ser_q <= serial;
      // A falling pin or a rising serial request is one delivery
      if ((pin_q && !pin_n) || (!ser_q && serial)) hits <= hits + 1;
    end
  end
endmodule
`default_nettype wire

// File: sim/mgmt_irq_group_tb.sv
// Purpose: Self-checking bench for the management interrupt group
// Assumes: Byte address is four times the word index
// Notes: Random enables and one-hot sources from a fixed seed, after two fixed ring b and route-bit cases
`timescale 1ns/1ps
`default_nettype none
module mgmt_irq_group_tb
  import mgmt_irq_pkg::*;
();
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] port1_pins = 8'h00, port1_event_gate = 8'h00;
  irq_sources_t sources = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic combined_mgmt_irq_n, mgmt_irq_out_pin_n, mgmt_irq_serial;
  logic [2:0] outs;
  int error_cnt = 0, cmp_count = 0, seed = 32'hc524, hits;
  irq_enables_t en = '0;
  irq_sources_t src_v;
  logic [7:0] sts = 8'h00, p, m;

  assign outs = {combined_mgmt_irq_n, mgmt_irq_out_pin_n, mgmt_irq_serial};

  mgmt_irq_group dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .port1_pins, .port1_event_gate, .sources, .combined_mgmt_irq_n,
    .mgmt_irq_out_pin_n, .mgmt_irq_serial
  );

  mgmt_irq_host host (
    .aclk, .aresetn, .pin_n(mgmt_irq_out_pin_n), .serial(mgmt_irq_serial), .hits
  );

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hung(input int n);
    if (n >= 40) begin
      error_cnt++;
      close_out();
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 40);
    bready <= 1'b0;
    hung(n);
    chk(bresp, er);
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge aclk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 40);
    rready <= 1'b0;
    hung(n);
    chk(rdata, ed);
    chk(rresp, er);
    @(posedge aclk);
  endtask

  // After reset, outputs are looked at on the falling edge, once settled
  task automatic rst_chk;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(outs, 3'b110);
    @(posedge aclk);
    for (int r = 0; r < 6; r++) rdc(adr(r), 32'h0, RESP_OKAY);
  endtask

  function automatic logic [7:0] adr(input int r);
    return {IDX_PORT1_STS + 6'(r), 2'b00};
  endfunction

  // Misc bits 7:6 are routes only, bit 5 enables ring b when zero
  function automatic logic [2:0] exp_out(irq_sources_t s, irq_enables_t e,
                                         logic [7:0] st, logic [7:0] g);
    logic q;
    q = |(s.periph & e.periph & 8'h9e) | |(s.misc & {2'b00, ~e.misc[5], e.misc[4:0]});
    q = q | |(s.port2 & e.port2) | |(s.port34 & e.port34) | |(s.port5 & e.port5);
    q = q | |(st & g);
    return {~q, ~(q & e.misc[7]), q & e.misc[6]};
  endfunction

  initial begin
    rst_chk();
    // Low byte not strobed: nothing may store
    wstrb <= 4'he;
    wrc(adr(5), 32'hff, RESP_OKAY);
    wstrb <= 4'hf;
    rdc(adr(5), 32'h0, RESP_OKAY);
    rdc(8'h00, 32'h0, RESP_SLVERR);
    wrc(8'h70, 32'hff, RESP_SLVERR);
    for (int k = 0; k < 14; k++) begin
      en = 40'({$random(seed), $random(seed)});
      src_v = 40'(1) << ($unsigned($random(seed)) % 40);
      // Ring b with all enables zero, then route bits posing as sources
      if (k < 2) begin
        en = (k == 0) ? 40'h0 : 40'he000;
        src_v = (k == 0) ? 40'h2000 : 40'hc000;
      end
      for (int r = 1; r < 6; r++) wrc(adr(r), 32'(en[8*r-8+:8]), RESP_OKAY);
      sources <= src_v;
      repeat (3) @(posedge aclk);
      chk(outs, exp_out(src_v, en, 8'h00, 8'h00));
      for (int r = 1; r < 6; r++)
        rdc(adr(r), 32'(en[8*r-8+:8] & (r == 1 ? 8'h9e : 8'hff)), RESP_OKAY);
    end
    sources <= '0;
    for (int k = 0; k < 5; k++) begin
      p = 8'($random(seed));
      m = (k == 0) ? 8'h00 : 8'($random(seed));
      port1_event_gate <= 8'($random(seed));
      port1_pins <= p;
      repeat (4) @(posedge aclk);
      port1_pins <= 8'h00;
      repeat (4) @(posedge aclk);
      sts = sts | p;
      rdc(adr(0), 32'(sts), RESP_OKAY);
      wrc(adr(0), 32'(m), RESP_OKAY);
      sts = sts & ~m;
      rdc(adr(0), 32'(sts), RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk(outs, exp_out('0, en, sts, port1_event_gate));
    end
    chk(32'(hits != 0), 32'h1);
    // Mid-run reset must return status and enables to zero
    rst_chk();
    close_out();
  end
endmodule
`default_nettype wire
